// ### tws_defs.svh
// Register offsets, field positions, reset values and status codes
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_OFF_CTRL      8'h00
`define TWS_OFF_STATUS    8'h04
`define TWS_OFF_DATA      8'h08
`define TWS_OFF_OWNADR    8'h0C
`define TWS_OFF_IRQ_STS   8'h10
`define TWS_OFF_IRQ_MASK  8'h14

`define TWS_CTRL_FLAG     7
`define TWS_CTRL_ACK      6
`define TWS_CTRL_BEGIN    5
`define TWS_CTRL_HALT     4
`define TWS_CTRL_ENABLE   2

`define TWS_RST_CTRL      8'h00
`define TWS_RST_OWNADR    8'hFE
`define TWS_RST_DATA      8'hFF

`define TWS_IRQ_EVENT     0
`define TWS_IRQ_WAKE      1

`define TWS_SC_OWN_W      8'h60
`define TWS_SC_ARB_OWN_W  8'h68
`define TWS_SC_GC_W       8'h70
`define TWS_SC_ARB_GC_W   8'h78
`define TWS_SC_RX_ACK     8'h80
`define TWS_SC_RX_NACK    8'h88
`define TWS_SC_GC_ACK     8'h90
`define TWS_SC_GC_NACK    8'h98
`define TWS_SC_STOP       8'hA0
`define TWS_SC_OWN_R      8'hA8
`define TWS_SC_ARB_OWN_R  8'hB0
`define TWS_SC_TX_ACK     8'hB8
`define TWS_SC_TX_NACK    8'hC0
`define TWS_SC_TX_EXTRA   8'hC8
`define TWS_SC_NONE       8'hF8

`endif

// ### tws_pkg.sv
// Types shared by the two-wire slave engine
package tws_pkg;

	// Engine states
	typedef enum logic [3:0] {
		TWS_IDLE,
		TWS_ADDR,
		TWS_AACK,
		TWS_RX,
		TWS_RACK,
		TWS_TXW,
		TWS_TX,
		TWS_TACK,
		TWS_IGNORE
	} tws_state_t;

	// Control register layout
	typedef struct packed {
		logic flag;
		logic ack_en;
		logic begin_req;
		logic halt_req;
		logic spare3;
		logic enable;
		logic spare1;
		logic int_en;
	} tws_ctrl_t;

	// One APB request as seen by the slave
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tws_apb_req_t;

endpackage

// ### tws_top.sv
// Two-wire slave engine with APB register file
// What this block does
// - A general-call data byte answered with not-acknowledge reports 0x98 and the byte is readable.
// - A stop or repeated start while still addressed reports 0xA0.
// - Leaving a terminal state, acknowledge-enable decides address recognition and begin-request asks for a start once the bus is free.
// - Status codes read as listed with the prescaler bits zero or masked off.
// - The upper seven bits of the own-address register are the bus address answered.
// - The own-address LSB set enables answering general call address 0x00, clear ignores it.
// - Once armed, a matching address with read bit enters transmit, otherwise receive.
// - After an accepted address the interrupt flag is set with a valid status code.
// - Losing arbitration then being addressed for read reports 0xB0 in transmit mode.
// - With acknowledge-enable cleared in transmit, the last byte goes out and 0xC0 or 0xC8 follows.
// - After that last byte the engine is not addressed and leaves the data line released.
// - With acknowledge-enable clear the own address is ignored while the bus is still watched.
// - In deep sleep with acknowledge-enable set an address match raises a wake-up.
// - After a wake-up the clock line stays low until software clears the interrupt flag.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "tws_defs.svh"

module tws_top
	import tws_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              I_REF_CLK,
	input  wire logic              I_RST_B,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic              I_SCL,
	input  wire logic              I_SDA,
	output logic                   O_SCL,
	output logic                   O_SCL_OE,
	output logic                   O_SDA,
	output logic                   O_SDA_OE,
	input  wire logic              I_SLEEP,
	input  wire logic              I_ARB_LOST,
	output logic                   O_WAKEUP,
	output logic                   O_START_REQ,
	output logic                   O_IRQ
);

	generate
		if (ADDR_W < 8) begin : g_chk
			$error("tws_top: ADDR_W must be at least 8");
		end
	endgenerate

	// Register hit on the low byte of the address, upper bits must be zero
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	tws_apb_req_t req;
	tws_ctrl_t    ctrl;
	tws_state_t   state;
	logic [4:0]   status;
	logic [1:0]   presc;
	logic [7:0]   data;
	logic [7:0]   ownadr;
	logic [1:0]   irq_sts;
	logic [1:0]   irq_mask;
	logic         scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic         slp_m, slp_s;
	logic         scl_rise, scl_fall, start_c, stop_c;
	logic [3:0]   bitcnt;
	logic [7:0]   shreg;
	logic         sda_oe, scl_oe;
	logic         addressed, dir, gcall, last, acked, arb;
	logic         ev_set, rx_load, wake;
	logic [7:0]   ev_code, rx_byte;
	logic         acc, wr, clr, halt_go, terminal, own_hit, gc_hit;
	logic         start_pending, bus_free;

	assign req = '{I_PSEL, I_PENABLE, I_PWRITE, I_PADDR[7:0], I_PWDATA};
	assign acc = req.sel & req.enable & O_PREADY;
	assign wr  = acc & req.write;
	// Writing one to the flag releases the engine
	assign clr = wr & hit(I_PADDR, `TWS_OFF_CTRL) &
		req.wdata[`TWS_CTRL_FLAG] & ctrl.flag;
	assign halt_go = clr & req.wdata[`TWS_CTRL_HALT];
	assign terminal = ({status, 3'b000} == `TWS_SC_RX_NACK) |
		({status, 3'b000} == `TWS_SC_GC_NACK) |
		({status, 3'b000} == `TWS_SC_STOP) |
		({status, 3'b000} == `TWS_SC_TX_NACK) |
		({status, 3'b000} == `TWS_SC_TX_EXTRA);
	assign own_hit = (shreg[7:1] == ownadr[7:1]);
	// General call is write only and gated by the own-address LSB
	assign gc_hit = (shreg[7:1] == 7'h00) & ownadr[0] & ~shreg[0];

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			slp_m <= 1'b0;
			slp_s <= 1'b0;
		end else begin
			scl_m <= I_SCL;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= I_SDA;
			sda_s <= sda_m;
			sda_d <= sda_s;
			slp_m <= I_SLEEP;
			slp_s <= slp_m;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	// Bus watcher and byte engine; the bus is watched even when not acking
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state     <= TWS_IDLE;
			bitcnt    <= 4'h0;
			shreg     <= 8'h00;
			sda_oe    <= 1'b0;
			addressed <= 1'b0;
			dir       <= 1'b0;
			gcall     <= 1'b0;
			last      <= 1'b0;
			acked     <= 1'b0;
			ev_set    <= 1'b0;
			ev_code   <= `TWS_SC_NONE;
			rx_load   <= 1'b0;
			rx_byte   <= 8'h00;
		end else begin
			ev_set  <= 1'b0;
			rx_load <= 1'b0;
			if (!ctrl.enable || halt_go) begin
				state     <= TWS_IDLE;
				sda_oe    <= 1'b0;
				addressed <= 1'b0;
			end else if (start_c || stop_c) begin
				if (addressed) begin
					ev_set  <= 1'b1;
					ev_code <= `TWS_SC_STOP;
				end
				addressed <= 1'b0;
				sda_oe    <= 1'b0;
				bitcnt    <= 4'h0;
				state     <= start_c ? TWS_ADDR : TWS_IDLE;
			end else begin
				case (state)
					TWS_ADDR: begin
						if (scl_rise) begin
							shreg  <= {shreg[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							// Acknowledge-enable isolates the engine
							if (ctrl.ack_en && (own_hit || gc_hit)) begin
								sda_oe <= 1'b1;
								dir    <= shreg[0];
								gcall  <= gc_hit;
								state  <= TWS_AACK;
							end else begin
								state <= TWS_IGNORE;
							end
						end
					end
					TWS_AACK: begin
						if (scl_fall) begin
							addressed <= 1'b1;
							ev_set    <= 1'b1;
							sda_oe    <= 1'b0;
							bitcnt    <= 4'h0;
							if (dir) begin
								ev_code <= arb ? `TWS_SC_ARB_OWN_R :
									`TWS_SC_OWN_R;
								state   <= TWS_TXW;
							end else begin
								if (gcall)
									ev_code <= arb ? `TWS_SC_ARB_GC_W :
										`TWS_SC_GC_W;
								else
									ev_code <= arb ? `TWS_SC_ARB_OWN_W :
										`TWS_SC_OWN_W;
								state <= TWS_RX;
							end
						end
					end
					TWS_RX: begin
						if (scl_rise) begin
							shreg  <= {shreg[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							rx_load <= 1'b1;
							rx_byte <= shreg;
							acked   <= ctrl.ack_en;
							sda_oe  <= ctrl.ack_en;
							state   <= TWS_RACK;
						end
					end
					TWS_RACK: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							ev_set <= 1'b1;
							bitcnt <= 4'h0;
							if (gcall)
								ev_code <= acked ? `TWS_SC_GC_ACK :
									`TWS_SC_GC_NACK;
							else
								ev_code <= acked ? `TWS_SC_RX_ACK :
									`TWS_SC_RX_NACK;
							if (acked) begin
								state <= TWS_RX;
							end else begin
								state     <= TWS_IGNORE;
								addressed <= 1'b0;
							end
						end
					end
					TWS_TXW: begin
						// Wait for software to load the byte and drop the flag
						if (!ctrl.flag && !ev_set) begin
							shreg  <= data;
							last   <= ~ctrl.ack_en;
							sda_oe <= ~data[7];
							bitcnt <= 4'h0;
							state  <= TWS_TX;
						end
					end
					TWS_TX: begin
						if (scl_fall) begin
							if (bitcnt == 4'h7) begin
								sda_oe <= 1'b0;
								state  <= TWS_TACK;
							end else begin
								shreg  <= {shreg[6:0], 1'b0};
								sda_oe <= ~shreg[6];
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					TWS_TACK: begin
						if (scl_rise) begin
							acked <= ~sda_s;
						end else if (scl_fall) begin
							ev_set <= 1'b1;
							if (last)
								ev_code <= acked ? `TWS_SC_TX_EXTRA :
									`TWS_SC_TX_NACK;
							else
								ev_code <= acked ? `TWS_SC_TX_ACK :
									`TWS_SC_TX_NACK;
							if (acked && !last) begin
								state <= TWS_TXW;
							end else begin
								// Line stays released so the master reads ones
								state     <= TWS_IGNORE;
								addressed <= 1'b0;
							end
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Clock stretch: once SCL is low, hold it while the flag is up
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			scl_oe <= 1'b0;
		else
			scl_oe <= ctrl.flag & (scl_oe | ~scl_s);
	end

	// Arbitration-lost memory, used by the next address phase
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			arb <= 1'b0;
		else if (I_ARB_LOST)
			arb <= 1'b1;
		else if (stop_c || (ev_set && state != TWS_AACK))
			arb <= 1'b0;
	end

	// Control register; hardware setting the flag wins over a clear
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ctrl <= tws_ctrl_t'(`TWS_RST_CTRL);
		end else begin
			if (wr && hit(I_PADDR, `TWS_OFF_CTRL)) begin
				ctrl.ack_en    <= req.wdata[`TWS_CTRL_ACK];
				ctrl.begin_req <= req.wdata[`TWS_CTRL_BEGIN];
				ctrl.halt_req  <= 1'b0;
				ctrl.spare3    <= 1'b0;
				ctrl.enable    <= req.wdata[`TWS_CTRL_ENABLE];
				ctrl.spare1    <= 1'b0;
				ctrl.int_en    <= req.wdata[0];
			end
			ctrl.flag <= ev_set | (ctrl.flag & ~clr);
		end
	end

	// Status code in the upper bits, prescaler in the low bits
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			status <= 5'(`TWS_SC_NONE >> 3);
			presc  <= 2'b00;
		end else begin
			if (ev_set)
				status <= ev_code[7:3];
			else if (clr)
				status <= 5'(`TWS_SC_NONE >> 3);
			if (wr && hit(I_PADDR, `TWS_OFF_STATUS))
				presc <= req.wdata[1:0];
		end
	end

	// Data and own-address registers; a received byte beats a write
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			data   <= `TWS_RST_DATA;
			ownadr <= `TWS_RST_OWNADR;
		end else begin
			if (rx_load)
				data <= rx_byte;
			else if (wr && hit(I_PADDR, `TWS_OFF_DATA))
				data <= req.wdata[7:0];
			if (wr && hit(I_PADDR, `TWS_OFF_OWNADR))
				ownadr <= req.wdata[7:0];
		end
	end

	// Start request after a terminal state, held until the bus is free
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			start_pending <= 1'b0;
			bus_free      <= 1'b1;
		end else begin
			if (start_c)
				bus_free <= 1'b0;
			else if (stop_c)
				bus_free <= 1'b1;
			if (clr && terminal && req.wdata[`TWS_CTRL_BEGIN])
				start_pending <= 1'b1;
			// A control write without begin drops the request at once
			else if (!ctrl.begin_req || !ctrl.enable ||
				(wr && hit(I_PADDR, `TWS_OFF_CTRL) &&
				!req.wdata[`TWS_CTRL_BEGIN]))
				start_pending <= 1'b0;
		end
	end

	// Wake-up: address accepted while the system sleeps
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			wake <= 1'b0;
		else if (ev_set && slp_s && addressed && state != TWS_IGNORE &&
			ev_code != `TWS_SC_STOP)
			wake <= 1'b1;
		else if (clr)
			wake <= 1'b0;
	end

	// Sticky interrupt causes, write one to clear, set wins
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			irq_sts  <= 2'b00;
			irq_mask <= 2'b00;
		end else begin
			if (wr && hit(I_PADDR, `TWS_OFF_IRQ_MASK))
				irq_mask <= req.wdata[1:0];
			irq_sts[`TWS_IRQ_EVENT] <= ev_set | (irq_sts[`TWS_IRQ_EVENT] &
				~(wr && hit(I_PADDR, `TWS_OFF_IRQ_STS) &&
				req.wdata[`TWS_IRQ_EVENT]));
			irq_sts[`TWS_IRQ_WAKE] <= (slp_s & ev_set) |
				(irq_sts[`TWS_IRQ_WAKE] &
				~(wr && hit(I_PADDR, `TWS_OFF_IRQ_STS) &&
				req.wdata[`TWS_IRQ_WAKE]));
		end
	end

	// APB: ready rises in the access phase, one cycle after setup
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= req.sel & ~req.enable;
			O_PSLVERR <= 1'b0;
			if (req.sel && !req.enable) begin
				O_PRDATA <= 32'h0000_0000;
				if (hit(I_PADDR, `TWS_OFF_CTRL))
					O_PRDATA[7:0] <= ctrl;
				else if (hit(I_PADDR, `TWS_OFF_STATUS))
					O_PRDATA[7:0] <= {status, 1'b0, presc};
				else if (hit(I_PADDR, `TWS_OFF_DATA))
					O_PRDATA[7:0] <= data;
				else if (hit(I_PADDR, `TWS_OFF_OWNADR))
					O_PRDATA[7:0] <= ownadr;
				else if (hit(I_PADDR, `TWS_OFF_IRQ_STS))
					O_PRDATA[1:0] <= irq_sts;
				else if (hit(I_PADDR, `TWS_OFF_IRQ_MASK))
					O_PRDATA[1:0] <= irq_mask;
				else
					O_PSLVERR <= 1'b1;
			end
		end
	end

	// Pin drivers and side outputs, all registered
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_SCL       <= 1'b0;
			O_SDA       <= 1'b0;
			O_SCL_OE    <= 1'b0;
			O_SDA_OE    <= 1'b0;
			O_WAKEUP    <= 1'b0;
			O_START_REQ <= 1'b0;
			O_IRQ       <= 1'b0;
		end else begin
			O_SCL       <= 1'b0; // Open drain: only ever drives low
			O_SDA       <= 1'b0;
			O_SCL_OE    <= scl_oe;
			O_SDA_OE    <= sda_oe;
			O_WAKEUP    <= wake;
			O_START_REQ <= start_pending & bus_free;
			O_IRQ       <= |(irq_sts & irq_mask);
		end
	end

endmodule

// ### tws_monitor.sv
// Port-level checks for the two-wire slave engine
`timescale 1ns/1ps
`include "tws_defs.svh"

module tws_monitor #(
	parameter int ADDR_W = 8
) (
	input wire logic              I_REF_CLK,
	input wire logic              I_RST_B,
	input wire logic              I_PSEL,
	input wire logic              I_PENABLE,
	input wire logic              I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0]       I_PWDATA,
	input wire logic              O_PREADY,
	input wire logic              O_PSLVERR,
	input wire logic              I_SCL,
	input wire logic              O_SCL_OE,
	input wire logic              I_SLEEP,
	input wire logic              O_WAKEUP,
	input wire logic              O_START_REQ
);
	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_B);

	logic ctrl_w;
	logic mapped;
	// Control write taking effect at this edge
	assign ctrl_w = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
		&& I_PADDR == `TWS_OFF_CTRL;
	assign mapped = I_PADDR inside {`TWS_OFF_CTRL, `TWS_OFF_STATUS,
		`TWS_OFF_DATA, `TWS_OFF_OWNADR, `TWS_OFF_IRQ_STS, `TWS_OFF_IRQ_MASK};

	chk_ready_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready stood too long");
	chk_unmapped_err: assert property (O_PREADY |-> O_PSLVERR == !mapped)
		else $error("error response wrong for address");
	chk_wake_in_sleep: assert property ($rose(O_WAKEUP) |-> $past(I_SLEEP, 3))
		else $error("wake-up without sleep");
	chk_wake_hold_scl: assert property (O_WAKEUP && O_SCL_OE |=> O_SCL_OE || !O_WAKEUP)
		else $error("clock released during wake-up");
	chk_flag_release: assert property (ctrl_w && I_PWDATA[7] |-> ##[1:4] (!O_SCL_OE && !O_WAKEUP))
		else $error("clock not released after flag clear");
	chk_begin_drop: assert property (ctrl_w && !I_PWDATA[5] |-> ##[1:2] !O_START_REQ)
		else $error("start request kept without begin");
	chk_stretch_low: assert property ($rose(O_SCL_OE) |-> !I_SCL)
		else $error("clock pulled while high");
endmodule

bind tws_top tws_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);

// ### tws_bus_master.sv
// Behavioural bus master on the far side of the two-wire link
`timescale 1ns/1ps

module tws_bus_master (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_oe,
	output logic      sda_oe,
	output logic      hung
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		hung = 1'b0;
	end

	// Six clocks a phase keeps levels and setup above four clocks
	task automatic half();
		repeat (6) @(posedge clk);
	endtask

	// Release the clock, then wait out any stretching by the slave
	task automatic rise();
		int n;
		scl_oe <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (scl !== 1'b1 && n < 20000);
		if (scl !== 1'b1)
			hung <= 1'b1;
		half();
	endtask

	// Data changes while the clock is low, read late in the high phase
	task automatic bitx(input logic b, output logic r);
		sda_oe <= ~b;
		half();
		rise();
		r = sda;
		scl_oe <= 1'b1;
		half();
	endtask

	// Works from idle and as a repeated start
	task automatic start();
		sda_oe <= 1'b0;
		half();
		rise();
		sda_oe <= 1'b1;
		half();
		scl_oe <= 1'b1;
		half();
	endtask

	task automatic stop();
		sda_oe <= 1'b1;
		half();
		rise();
		sda_oe <= 1'b0;
		half();
	endtask

	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, ack);
	endtask

	// Acknowledging a last byte is done only when the bench asks
	task automatic rbyte(input logic ack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			v[i] = r;
		end
		bitx(ack, r);
	endtask
endmodule

// ### tws_top_test.sv
// Self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
`include "tws_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end

module tws_top_test;
	localparam logic [6:0] ADR = 7'h2A;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        sleep = 1'b0;
	logic        arb = 1'b0;
	logic        m_scl, m_sda, hung, ack;
	logic        pready, pslverr, scl_oe, sda_oe, wake, sreq, irq;
	logic [31:0] prdata, want;
	logic [7:0]  gd, td, d;
	logic [31:0] notes[$];
	int          failures = 0;
	int          comparisons = 0;
	integer      seed = 32'ha2ea;
	// Open-drain lines with pull-ups
	wire         scl = ~(m_scl | scl_oe);
	wire         sda = ~(m_sda | sda_oe);

	always #20 clk = ~clk;

	tws_top dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_SCL(scl), .I_SDA(sda), .O_SCL(),
		.O_SCL_OE(scl_oe), .O_SDA(), .O_SDA_OE(sda_oe), .I_SLEEP(sleep),
		.I_ARB_LOST(arb), .O_WAKEUP(wake), .O_START_REQ(sreq), .O_IRQ(irq));

	tws_bus_master m_u (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl),
		.sda_oe(m_sda), .hung(hung));

	task automatic wrap_up();
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One APB transfer; a read leaves its expected word as a note
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
		int n;
		if (!w)
			notes.push_back(32'(v));
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(v);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Registered outputs need two more edges before callers look
		repeat (2) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		apb(1'b1, a, v);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		apb(1'b0, a, v);
	endtask

	// Prescaler bits are left at 3, so codes read back with them set
	task automatic rs(input logic [7:0] c);
		apb(1'b0, `TWS_OFF_STATUS, c | 8'h03);
	endtask

	// Compare each completed read with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			want = notes.pop_front();
			`CHK(prdata, want)
			`CHK(pslverr, paddr > `TWS_OFF_IRQ_MASK)
		end
	end

	// A stuck clock line ends the run as a failure
	always @(posedge clk) begin
		if (hung === 1'b1) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`TWS_OFF_STATUS, `TWS_SC_NONE);
		rd(`TWS_OFF_OWNADR, `TWS_RST_OWNADR);
		rd(`TWS_OFF_DATA, `TWS_RST_DATA);
		rd(8'h20, 8'h00);
		wr(`TWS_OFF_STATUS, 8'h03);
		wr(`TWS_OFF_OWNADR, {ADR, 1'b1});
		wr(`TWS_OFF_IRQ_MASK, 8'h01);
		wr(`TWS_OFF_CTRL, 8'h45);
		// General call, then a data byte refused with acknowledge off
		gd = 8'($random(seed));
		m_u.start();
		m_u.wbyte(8'h00, ack);
		`CHK(ack, 1'b0)
		rs(`TWS_SC_GC_W);
		`CHK(irq, 1'b1)
		wr(`TWS_OFF_CTRL, 8'h85);
		m_u.wbyte(gd, ack);
		`CHK(ack, 1'b1)
		rs(`TWS_SC_GC_NACK);
		rd(`TWS_OFF_DATA, gd);
		wr(`TWS_OFF_CTRL, 8'hC5);
		// General call refused while its enable bit is clear
		wr(`TWS_OFF_OWNADR, {ADR, 1'b0});
		m_u.start();
		m_u.wbyte(8'h00, ack);
		`CHK(ack, 1'b1)
		wr(`TWS_OFF_OWNADR, {ADR, 1'b1});
		// Own address ignored while acknowledge is off, then resumed
		wr(`TWS_OFF_CTRL, 8'h05);
		m_u.start();
		m_u.wbyte({ADR, 1'b0}, ack);
		`CHK(ack, 1'b1)
		wr(`TWS_OFF_CTRL, 8'h45);
		m_u.start();
		m_u.wbyte({ADR, 1'b0}, ack);
		`CHK(ack, 1'b0)
		rs(`TWS_SC_OWN_W);
		wr(`TWS_OFF_CTRL, 8'hC5);
		m_u.stop();
		rs(`TWS_SC_STOP);
		wr(`TWS_OFF_CTRL, 8'hE5);
		`CHK(sreq, 1'b1)
		wr(`TWS_OFF_CTRL, 8'h45);
		`CHK(sreq, 1'b0)
		// Last byte with acknowledge off while the master wants more
		td = 8'($random(seed));
		m_u.start();
		m_u.wbyte({ADR, 1'b1}, ack);
		rs(`TWS_SC_OWN_R);
		wr(`TWS_OFF_DATA, td);
		wr(`TWS_OFF_CTRL, 8'h85);
		m_u.rbyte(1'b0, d);
		`CHK(d, td)
		rs(`TWS_SC_TX_EXTRA);
		wr(`TWS_OFF_CTRL, 8'hC5);
		m_u.rbyte(1'b1, d);
		`CHK(d, 8'hFF)
		// Arbitration lost, then read by the winning master
		m_u.start();
		arb <= 1'b1;
		@(posedge clk);
		arb <= 1'b0;
		m_u.wbyte({ADR, 1'b1}, ack);
		rs(`TWS_SC_ARB_OWN_R);
		wr(`TWS_OFF_DATA, td);
		wr(`TWS_OFF_CTRL, 8'h85);
		m_u.rbyte(1'b1, d);
		`CHK(d, td)
		rs(`TWS_SC_TX_NACK);
		wr(`TWS_OFF_CTRL, 8'hC5);
		m_u.stop();
		// Match while asleep holds the clock until the flag clears
		wr(`TWS_OFF_IRQ_STS, 8'h03);
		`CHK(irq, 1'b0)
		sleep <= 1'b1;
		m_u.start();
		m_u.wbyte({ADR, 1'b0}, ack);
		`CHK(ack, 1'b0)
		// Stretch and wake-up come out a few edges after the ack bit
		repeat (3) @(posedge clk);
		`CHK(wake, 1'b1)
		`CHK(scl_oe, 1'b1)
		rd(`TWS_OFF_IRQ_STS, 8'h03);
		wr(`TWS_OFF_CTRL, 8'hC5);
		repeat (4) @(posedge clk);
		`CHK(scl_oe, 1'b0)
		`CHK(wake, 1'b0)
		sleep <= 1'b0;
		m_u.stop();
		`CHK(hung, 1'b0)
		wrap_up();
	end
endmodule
